// ===== common/osm_pkg.sv
package osm_pkg;
   // ==========================================
   // clock and measurement widths
   localparam int CLK_HZ = 20_000_000;
   localparam int CLK_MHZ = CLK_HZ / 1_000_000;
   localparam int PW = 20;
   localparam int SW = 10;
   localparam int GW = 16;
   localparam int DW = 32;
   localparam int AW = 8;
   localparam int EVW = 4;

   // ==========================================
   // frequency limits
   // sensors above this rate are not read reliably
   localparam int SENSOR_MAX_HZ = 1000;
   localparam int RANGE_HZ = 1200;
   localparam int RANGE_CYC = CLK_HZ / RANGE_HZ;
   localparam int SET_MIN_HZ = 50;
   localparam int SET_MAX_HZ = SENSOR_MAX_HZ;
   localparam logic [SW-1:0] SET_RST = 10'h032;
   localparam int AUTO_PCT = 95;
   localparam int FULL_PCT = 100;

   // ==========================================
   // timing
   localparam int GAP_US = 20;
   localparam int GAP_CYC = GAP_US * CLK_MHZ;
   localparam int STILL_MS = 40;
   localparam int STILL_CYC = STILL_MS * (CLK_HZ / 1000);

   // ==========================================
   // register map
   localparam logic [AW-1:0] REG_CTRL = 8'h00;
   localparam logic [AW-1:0] REG_SETPT = 8'h04;
   localparam logic [AW-1:0] REG_STATUS = 8'h08;
   localparam logic [AW-1:0] REG_MASK = 8'h0c;
   localparam logic [AW-1:0] REG_STATE = 8'h10;
   localparam logic [AW-1:0] REG_PERIOD = 8'h14;

   localparam logic [1:0] MODE_AUTO = 2'h0;
   localparam logic [1:0] MODE_MANUAL = 2'h1;
   localparam logic [1:0] MODE_CTL = 2'h2;
   localparam logic [1:0] MODE_RST = MODE_MANUAL;

   localparam int EV_OVER = 0;
   localparam int EV_SENS = 1;
   localparam int EV_ON = 2;
   localparam int EV_OFF = 3;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ARM,
      ST_REL,
      ST_RUN,
      ST_TRIP,
      ST_FAIL
   } osm_state_t;
endpackage

// ===== core/osm_channel.sv
module osm_channel #(
   parameter int STILL_CYC = osm_pkg::STILL_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // sensor level
   input wire logic sense,
   // measurement
   output logic edgeSeen,
   output logic riseSeen,
   output logic [osm_pkg::PW-1:0] period,
   output logic still
);
   typedef struct packed {
      logic lvl;
      logic [osm_pkg::PW-1:0] cnt;
      logic [osm_pkg::PW-1:0] period;
      logic still;
   } osm_chan_t;

   localparam logic [osm_pkg::PW-1:0] STILL_MAX =
      osm_pkg::PW'(STILL_CYC);

   osm_chan_t chReg;
   osm_chan_t chNext;

   assign edgeSeen = sense != chReg.lvl;
   assign riseSeen = sense & ~chReg.lvl;
   assign period = chReg.period;
   assign still = chReg.still;

   // ==========================================
   // period between rising edges
   always_comb
   begin
      chNext = chReg;
      chNext.lvl = sense;
      if (riseSeen)
      begin
         chNext.cnt = '0;
         // first edge after standstill has no valid period
         chNext.period = chReg.still ? STILL_MAX : chReg.cnt + 1'b1;
         chNext.still = 1'b0;
      end
      else if (chReg.cnt < STILL_MAX)
         chNext.cnt = chReg.cnt + 1'b1;
      else
      begin
         chNext.still = 1'b1;
         chNext.period = STILL_MAX;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         chReg.lvl <= 1'b0;
         chReg.cnt <= '0;
         chReg.period <= STILL_MAX;
         chReg.still <= 1'b1;
      end
      else
         chReg <= chNext;
   end
endmodule // osm_channel

// ===== core/osm_monitor.sv
module osm_monitor #(
   parameter int STILL_CYC = osm_pkg::STILL_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // coils and terminals
   input wire logic safetyActivationCoil,
   input wire logic restartCoil,
   input wire logic encoderTerminalA,
   input wire logic encoderTerminalB,
   // contacts and interrupt
   output logic safeEnableContact,
   output logic faultContact,
   output logic irq,
   // register port
   input wire logic [osm_pkg::AW-1:0] regAddr,
   input wire logic [osm_pkg::DW-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [osm_pkg::DW-1:0] regRdData
);
   typedef struct packed {
      osm_pkg::osm_state_t state;
      logic [1:0] mode;
      logic [osm_pkg::SW-1:0] setpt;
      logic [osm_pkg::EVW-1:0] status;
      logic [osm_pkg::EVW-1:0] mask;
      logic rstLvl;
      logic started;
      logic measDone;
      logic lastCh;
      logic [osm_pkg::GW-1:0] gap;
      logic overErr;
      logic sensErr;
      logic enable;
      logic fault;
      logic irq;
      logic [osm_pkg::DW-1:0] rdData;
   } osm_mon_t;

   localparam logic [39:0] CLK_L = 40'(osm_pkg::CLK_HZ);
   localparam logic [39:0] AUTO_L =
      40'(osm_pkg::CLK_HZ * osm_pkg::FULL_PCT);
   localparam logic [39:0] PCT_L = 40'(osm_pkg::AUTO_PCT);
   localparam logic [osm_pkg::PW-1:0] RANGE_L =
      osm_pkg::PW'(osm_pkg::RANGE_CYC);
   localparam logic [osm_pkg::GW-1:0] GAP_L =
      osm_pkg::GW'(osm_pkg::GAP_CYC);

   osm_mon_t r_reg;
   osm_mon_t r_next;

   logic [1:0] termV;
   logic [1:0] edgeV;
   logic [1:0] riseV;
   logic [1:0] stillV;
   logic [1:0][osm_pkg::PW-1:0] periodV;
   logic rstRise;
   logic rstFall;
   logic edgeAny;
   logic [29:0] prod;
   logic [39:0] prodW;
   logic overHit;
   logic slowOk;
   logic rangeErr;
   logic bothLow;
   logic overlap;
   logic deadCh;
   logic sensFault;
   logic [osm_pkg::EVW-1:0] ev;
   logic [osm_pkg::EVW-1:0] clr;

   // ==========================================
   // channel measurement
   assign termV = {encoderTerminalB, encoderTerminalA};

   for (genvar i = 0; i < 2; i++)
   begin : g_ch
      osm_channel #(
         .STILL_CYC(STILL_CYC)
      ) u_ch (
         .clk(clk),
         .resetn(resetn),
         .sense(termV[i]),
         .edgeSeen(edgeV[i]),
         .riseSeen(riseV[i]),
         .period(periodV[i]),
         .still(stillV[i])
      );
   end

   assign safeEnableContact = r_reg.enable;
   assign faultContact = r_reg.fault;
   assign irq = r_reg.irq;
   assign regRdData = r_reg.rdData;

   // ==========================================
   // evaluation
   always_comb
   begin
      rstRise = restartCoil & ~r_reg.rstLvl;
      rstFall = ~restartCoil & r_reg.rstLvl;
      edgeAny = |edgeV;
      // period times setpoint against clock rate avoids a divider
      prod = periodV[0] * r_reg.setpt;
      prodW = 40'(prod) * PCT_L;
      overHit = r_reg.measDone && (40'(prod) < CLK_L);
      slowOk = stillV[0] || (prodW >= AUTO_L);
      // range check leaves margin above the installation limit
      rangeErr = r_reg.measDone && !stillV[0] &&
         (periodV[0] < RANGE_L);
      bothLow = r_reg.started && !termV[0] && !termV[1];
      overlap = (edgeV[0] && edgeV[1]) ||
         (edgeAny && (r_reg.gap < GAP_L) &&
         (edgeV[0] ? r_reg.lastCh : !r_reg.lastCh));
      deadCh = r_reg.started && (stillV[0] != stillV[1]);
      sensFault = safetyActivationCoil &&
         (overlap || rangeErr || bothLow || deadCh);
   end

   // ==========================================
   // next state
   always_comb
   begin
      r_next = r_reg;
      r_next.rstLvl = restartCoil;
      r_next.measDone = riseV[0];
      clr = '0;
      ev = '0;
      if (edgeAny)
      begin
         r_next.gap = '0;
         r_next.lastCh = edgeV[1];
      end
      else if (r_reg.gap < GAP_L)
         r_next.gap = r_reg.gap + 1'b1;

      if (!safetyActivationCoil)
      begin
         // dropping the activation coil is the only acknowledge
         r_next.state = osm_pkg::ST_IDLE;
         r_next.started = 1'b0;
         r_next.overErr = 1'b0;
         r_next.sensErr = 1'b0;
      end
      else
      begin
         if (edgeAny)
            r_next.started = 1'b1;
         if (sensFault)
         begin
            r_next.sensErr = 1'b1;
            r_next.state = osm_pkg::ST_FAIL;
         end
         else
         begin
            case (r_reg.state)
               osm_pkg::ST_IDLE:
                  r_next.state = osm_pkg::ST_ARM;
               osm_pkg::ST_ARM:
               begin
                  if (r_reg.mode == osm_pkg::MODE_AUTO)
                     r_next.state = osm_pkg::ST_RUN;
                  else if (rstRise)
                     r_next.state = (r_reg.mode == osm_pkg::MODE_CTL) ?
                        osm_pkg::ST_RUN : osm_pkg::ST_REL;
               end
               osm_pkg::ST_REL:
               begin
                  // manual start closes on release of the button
                  if (rstFall)
                     r_next.state = osm_pkg::ST_RUN;
               end
               osm_pkg::ST_RUN:
               begin
                  if (overHit)
                  begin
                     r_next.state = osm_pkg::ST_TRIP;
                     r_next.overErr = 1'b1;
                  end
                  else
                     r_next.state = osm_pkg::ST_RUN;
               end
               osm_pkg::ST_TRIP:
               begin
                  if (r_reg.mode == osm_pkg::MODE_AUTO)
                  begin
                     if (slowOk)
                        r_next.state = osm_pkg::ST_RUN;
                  end
                  else if (rstRise)
                     r_next.state = (r_reg.mode == osm_pkg::MODE_CTL) ?
                        osm_pkg::ST_RUN : osm_pkg::ST_REL;
               end
               osm_pkg::ST_FAIL:
                  r_next.state = osm_pkg::ST_FAIL;
               default:
                  r_next.state = osm_pkg::ST_IDLE;
            endcase
         end
      end

      r_next.enable = r_next.state == osm_pkg::ST_RUN;
      r_next.fault = r_next.overErr | r_next.sensErr;
      ev[osm_pkg::EV_OVER] = r_next.overErr & ~r_reg.overErr;
      ev[osm_pkg::EV_SENS] = r_next.sensErr & ~r_reg.sensErr;
      ev[osm_pkg::EV_ON] = r_next.enable & ~r_reg.enable;
      ev[osm_pkg::EV_OFF] = ~r_next.enable & r_reg.enable;

      // register writes
      if (regWr)
      begin
         case (regAddr)
            osm_pkg::REG_CTRL:
            begin
               // the unused mode code is ignored
               if (regWrData[1:0] != 2'h3)
                  r_next.mode = regWrData[1:0];
            end
            osm_pkg::REG_SETPT:
            begin
               if (regWrData < osm_pkg::SET_MIN_HZ)
                  r_next.setpt = osm_pkg::SW'(osm_pkg::SET_MIN_HZ);
               else if (regWrData > osm_pkg::SET_MAX_HZ)
                  r_next.setpt = osm_pkg::SW'(osm_pkg::SET_MAX_HZ);
               else
                  r_next.setpt = regWrData[osm_pkg::SW-1:0];
            end
            osm_pkg::REG_STATUS:
               clr = regWrData[osm_pkg::EVW-1:0];
            osm_pkg::REG_MASK:
               r_next.mask = regWrData[osm_pkg::EVW-1:0];
            default:
               clr = '0;
         endcase
      end
      // a new event in the clearing cycle survives
      r_next.status = (r_reg.status & ~clr) | ev;
      r_next.irq = |(r_next.status & r_next.mask);

      // register reads, data valid for one cycle only
      r_next.rdData = '0;
      if (regRd)
      begin
         case (regAddr)
            osm_pkg::REG_CTRL:
               r_next.rdData = 32'(r_reg.mode);
            osm_pkg::REG_SETPT:
               r_next.rdData = 32'(r_reg.setpt);
            osm_pkg::REG_STATUS:
               r_next.rdData = 32'(r_reg.status);
            osm_pkg::REG_MASK:
               r_next.rdData = 32'(r_reg.mask);
            osm_pkg::REG_STATE:
               r_next.rdData = 32'({r_reg.started, r_reg.sensErr,
                  r_reg.overErr, r_reg.enable, r_reg.state});
            osm_pkg::REG_PERIOD:
               r_next.rdData = 32'(periodV[0]);
            default:
               r_next.rdData = '0;
         endcase
      end
   end

   // ==========================================
   // state register
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         r_reg.state <= osm_pkg::ST_IDLE;
         r_reg.mode <= osm_pkg::MODE_RST;
         r_reg.setpt <= osm_pkg::SET_RST;
         r_reg.status <= '0;
         r_reg.mask <= '0;
         r_reg.rstLvl <= 1'b0;
         r_reg.started <= 1'b0;
         r_reg.measDone <= 1'b0;
         r_reg.lastCh <= 1'b0;
         r_reg.gap <= GAP_L;
         r_reg.overErr <= 1'b0;
         r_reg.sensErr <= 1'b0;
         r_reg.enable <= 1'b0;
         r_reg.fault <= 1'b0;
         r_reg.irq <= 1'b0;
         r_reg.rdData <= '0;
      end
      else
         r_reg <= r_next;
   end

   // ==========================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   trip_opens_a: assert property (
      (r_reg.state == osm_pkg::ST_RUN && overHit) |=>
      !safeEnableContact ##1 !safeEnableContact)
      else $error("enable stayed closed after overspeed");

   err_hold_a: assert property (
      (faultContact && safetyActivationCoil) |=> faultContact)
      else $error("error dropped while activation held");

   err_ack_a: assert property (
      !safetyActivationCoil |=> !faultContact)
      else $error("error not acknowledged by activation drop");

   ctl_start_a: assert property (
      (r_reg.state == osm_pkg::ST_ARM && r_reg.mode == osm_pkg::MODE_CTL
      && rstRise && safetyActivationCoil && !sensFault)
      |=> safeEnableContact)
      else $error("controlled start did not close enable");

   reset_rearm_a: assert property (
      (r_reg.state == osm_pkg::ST_TRIP && r_reg.mode != osm_pkg::MODE_AUTO
      && !rstRise) |=> !safeEnableContact)
      else $error("enable returned without restart coil");

   run_hold_a: assert property (
      (r_reg.state == osm_pkg::ST_RUN && safetyActivationCoil
      && !sensFault && !overHit) |=> safeEnableContact)
      else $error("enable dropped below the setpoint");

   first_edge_a: assert property (
      $rose(r_reg.started) |-> $past(edgeAny))
      else $error("evaluation started without an edge");

   edge_clash_a: assert property (
      (safetyActivationCoil && edgeV[0] && edgeV[1]) |=>
      (faultContact && !safeEnableContact))
      else $error("coincident edges not flagged");

   setpt_range_a: assert property (
      r_reg.setpt >= 10'h032 && r_reg.setpt <= 10'h3e8)
      else $error("setpoint outside its range");

   auto_resume_a: assert property (
      (r_reg.state == osm_pkg::ST_TRIP && r_reg.mode == osm_pkg::MODE_AUTO
      && slowOk && safetyActivationCoil && !sensFault)
      |=> safeEnableContact)
      else $error("automatic restart did not resume");

   wire_break_a: assert property (
      (safetyActivationCoil && bothLow) |=>
      (faultContact && !safeEnableContact))
      else $error("wire break not signalled");
endmodule // osm_monitor

// ===== testbench/osm_cam_sensors.sv
module osm_cam_sensors (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // wheel speed and cable fault from the bench
   input wire logic [31:0] camPeriod,
   input wire logic wireCut,
   // sensor terminals
   output logic terminalA,
   output logic terminalB
);
   timeunit 1ns;
   timeprecision 1ps;
   int phase;
   int perReg;
   // ==========================================
   // cam wheel
   // a new period is taken only at a full turn, so no short pulse appears
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         perReg <= camPeriod;
         // start at a full turn so the first measured period is a whole one
         phase <= 0;
      end
      else if (phase >= perReg - 1)
      begin
         perReg <= camPeriod;
         phase <= 0;
      end
      else
         phase <= phase + 1;
   end
   // ==========================================
   // sensor levels
   // overlapping cams keep one sensor actuated; edges stay a quarter apart
   // a cut cable leaves the input on its pull-down
   assign terminalA = !wireCut && (phase < 3 * perReg / 4);
   assign terminalB = !wireCut &&
      (phase >= perReg / 2 || phase < perReg / 4);
endmodule // osm_cam_sensors

// ===== testbench/testbench.sv
`define CHK(got, exp) \
   begin \
      nTests++; \
      if ((got) !== (exp)) \
      begin \
         fails++; \
         $display("unexpected t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, resetn, sa, rc, tA, tB, en, flt, irq, wr, rd, cut;
   logic [osm_pkg::AW-1:0] addr;
   logic [osm_pkg::DW-1:0] wdata, rdata;
   logic [15:0] lfsr;
   int camPer, fails, nTests, i, v;
   int mMode, mSet, mStat, mMask, mEn, mFlt;

   osm_monitor #(.STILL_CYC(30000)) dut (.clk(clk), .resetn(resetn),
      .safetyActivationCoil(sa), .restartCoil(rc), .encoderTerminalA(tA),
      .encoderTerminalB(tB), .safeEnableContact(en), .faultContact(flt),
      .irq(irq), .regAddr(addr), .regWrData(wdata), .regWr(wr), .regRd(rd),
      .regRdData(rdata));
   osm_cam_sensors cams (.clk(clk), .resetn(resetn), .camPeriod(camPer),
      .wireCut(cut), .terminalA(tA), .terminalB(tB));

   always #25 clk = ~clk;

   // ==========================================
   // bus and checking tasks
   function automatic logic [15:0] lfsrNext(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic wr32(input logic [7:0] a, input int d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= 32'(d);
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic chkReg(input logic [7:0] a, input int e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK(rdata, 32'(e))
   endtask
   task automatic chkOut();
      `CHK(en, 1'(mEn))
      `CHK(flt, 1'(mFlt))
      `CHK(irq, 1'((mStat & mMask) != 0))
   endtask
   function automatic void setEn(input int e);
      if (mEn != e)
         mStat |= (e != 0) ? 4 : 8;
      mEn = e;
   endfunction
   task automatic waitEn(input logic e, input int lim);
      for (int k = 0; k < lim && en !== e; k++)
      begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", nTests, fails);
      if (fails == 0 && nTests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ==========================================
   // watchdog
   initial
   begin
      repeat (120000) @(posedge clk);
      fails++;
      conclude();
   end

   // ==========================================
   // main sequence
   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      sa = 1'b0;
      rc = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      cut = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      camPer = 22500;
      fails = 0;
      nTests = 0;
      lfsr = 16'h002c;
      mMode = 1;
      mSet = 50;
      mStat = 0;
      mMask = 0;
      mEn = 0;
      mFlt = 0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      chkReg(osm_pkg::REG_CTRL, mMode);
      chkReg(osm_pkg::REG_SETPT, mSet);
      chkReg(osm_pkg::REG_STATUS, 0);
      chkReg(osm_pkg::REG_MASK, 0);
      chkOut();
      wr32(8'h20, -1);
      chkReg(8'h20, 0);
      // setpoint edges first, then random values
      for (i = 0; i < 6; i++)
      begin
         v = (i == 0) ? 49 : (i == 1) ? 1001 : (i == 2) ? 1000 :
            (i == 3) ? 50 : int'(lfsr[10:0]);
         lfsr = lfsrNext(lfsr);
         wr32(osm_pkg::REG_SETPT, v);
         mSet = (v < 50) ? 50 : (v > 1000) ? 1000 : v;
         chkReg(osm_pkg::REG_SETPT, mSet);
      end
      // code 3 is refused, leaving controlled start selected
      for (i = 0; i < 4; i++)
      begin
         wr32(osm_pkg::REG_CTRL, i);
         if (i != 3)
            mMode = i;
         chkReg(osm_pkg::REG_CTRL, mMode);
      end
      wr32(osm_pkg::REG_SETPT, 950);
      wr32(osm_pkg::REG_MASK, 1);
      mSet = 950;
      mMask = 1;
      chkReg(osm_pkg::REG_MASK, mMask);
      // controlled start while the wheel turns slowly
      @(posedge clk);
      sa <= 1'b1;
      repeat (3) @(posedge clk);
      rc <= 1'b1;
      waitEn(1'b1, 10);
      setEn(1);
      chkOut();
      @(posedge clk);
      rc <= 1'b0;
      chkReg(osm_pkg::REG_STATUS, mStat);
      for (i = 0; i < 23; i++)
      begin
         repeat (1000) @(posedge clk);
         #1;
         chkOut();
      end
      // overspeed
      @(posedge clk);
      camPer <= 20500;
      waitEn(1'b0, 46000);
      mStat |= 1;
      mFlt = 1;
      setEn(0);
      chkOut();
      chkReg(osm_pkg::REG_STATUS, mStat);
      // automatic restart once the speed falls 5 % below the setpoint
      wr32(osm_pkg::REG_CTRL, 0);
      mMode = 0;
      @(posedge clk);
      camPer <= 22500;
      waitEn(1'b1, 46000);
      setEn(1);
      chkOut();
      wr32(osm_pkg::REG_STATUS, 1);
      mStat &= ~1;
      repeat (2) @(posedge clk);
      #1;
      chkOut();
      chkReg(osm_pkg::REG_STATUS, mStat);
      // dropping the activation coil acknowledges the error
      @(posedge clk);
      sa <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      mFlt = 0;
      setEn(0);
      chkOut();
      // manual start closes only after the restart coil is released
      wr32(osm_pkg::REG_CTRL, 1);
      mMode = 1;
      @(posedge clk);
      sa <= 1'b1;
      repeat (3) @(posedge clk);
      rc <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chkOut();
      @(posedge clk);
      rc <= 1'b0;
      waitEn(1'b1, 10);
      setEn(1);
      chkOut();
      // both sensor cables cut
      @(posedge clk);
      cut <= 1'b1;
      waitEn(1'b0, 10);
      mStat |= 2;
      mFlt = 1;
      setEn(0);
      chkOut();
      chkReg(osm_pkg::REG_STATUS, mStat);
      conclude();
   end
endmodule // testbench
